// >>> rtl/aeacc_pkg.sv
// Shared constants and types of the apparent energy accumulator.
// Assumes a single clk_sys domain and the plain register port of aeacc_top.
package aeacc_pkg;

	// ************************************************************
	// Datapath widths
	// ************************************************************
	localparam int ACC_W = 52;
	localparam int TOT_W = 24;
	localparam int TOT_LSB = ACC_W - TOT_W;
	localparam int DIVISOR_W = 8;
	localparam int HCYC_W = 16;
	localparam int GAIN_W = 12;
	localparam int CFDIV_W = 12;
	localparam int PHASE_W = 29;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 24;

	// Clocks between two accumulated samples
	localparam int TICK_CLKS = 4;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [ADDR_W-1:0] A_ENERGY_TOTAL = 5'h01;
	localparam logic [ADDR_W-1:0] A_ENERGY_RCLR = 5'h02;
	localparam logic [ADDR_W-1:0] A_LINE_APP = 5'h03;
	localparam logic [ADDR_W-1:0] A_LINE_ACT = 5'h04;
	localparam logic [ADDR_W-1:0] A_DIVISOR = 5'h05;
	localparam logic [ADDR_W-1:0] A_HALF_CYC = 5'h06;
	localparam logic [ADDR_W-1:0] A_MODE = 5'h07;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK = 5'h08;
	localparam logic [ADDR_W-1:0] A_IRQ_STATUS = 5'h09;
	localparam logic [ADDR_W-1:0] A_ACT_GAIN = 5'h0A;
	localparam logic [ADDR_W-1:0] A_CF_NUM = 5'h0B;
	localparam logic [ADDR_W-1:0] A_CF_DEN = 5'h0C;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int MODE_LINE_CYC_BIT = 7;
	localparam int MODE_W = 8;
	localparam int ST_HALF_POS = 0;
	localparam int ST_HALF_NEG = 1;
	localparam int ST_OVF = 2;
	localparam int ST_UNF = 3;
	localparam int ST_EOC = 4;
	localparam int ST_W = 5;
	localparam logic [HCYC_W-1:0] HALF_CYC_RST = 16'h0000;
	localparam logic [DIVISOR_W-1:0] DIVISOR_RST = 8'h00;
	localparam logic [MODE_W-1:0] MODE_RST = 8'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} aeacc_req_s;

	typedef enum logic {DIV_IDLE, DIV_RUN} aeacc_div_e;

endpackage

// >>> rtl/aeacc_div.sv
// Sequential signed divider: wide dividend by an unsigned 8-bit divisor.
// Assumes start is only raised while busy_r is low; zero divides as one.
`timescale 1ns/10ps
module aeacc_div #(
	parameter int W = 52,
	parameter int DW = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [DW-1:0] divisor,
	output logic [W-1:0] quotient_r,
	output logic done_r,
	output logic busy_r
);

	generate
		if (W < 2 || DW < 1 || DW >= W)
		begin : g_chk
			$error("aeacc_div: unsupported widths");
		end
	endgenerate

	aeacc_pkg::aeacc_div_e state_r, state_nxt;
	logic [W-1:0] dvd_r, dvd_nxt, quo_r, quo_nxt, q_out_nxt;
	logic [DW:0] rem_r, rem_nxt, trial;
	logic [DW-1:0] dsr_r, dsr_nxt;
	logic neg_r, neg_nxt, done_nxt;
	logic [$clog2(W+1)-1:0] cnt_r, cnt_nxt;

	always_comb
	begin
		state_nxt = state_r;
		dvd_nxt = dvd_r;
		quo_nxt = quo_r;
		rem_nxt = rem_r;
		dsr_nxt = dsr_r;
		neg_nxt = neg_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		q_out_nxt = quotient_r;
		trial = {rem_r[DW-1:0], dvd_r[W-1]};
		case (state_r)
			aeacc_pkg::DIV_IDLE:
			begin
				if (start)
				begin
					// Divide the magnitude, restore the sign at the end
					neg_nxt = dividend[W-1];
					dvd_nxt = dividend[W-1] ? (~dividend + 1'b1) : dividend;
					dsr_nxt = (divisor == '0) ? DW'(1) : divisor;
					rem_nxt = '0;
					quo_nxt = '0;
					cnt_nxt = ($clog2(W+1))'(W);
					state_nxt = aeacc_pkg::DIV_RUN;
				end
			end
			aeacc_pkg::DIV_RUN:
			begin
				dvd_nxt = {dvd_r[W-2:0], 1'b0};
				if (trial >= {1'b0, dsr_r})
				begin
					rem_nxt = trial - {1'b0, dsr_r};
					quo_nxt = {quo_r[W-2:0], 1'b1};
				end
				else
				begin
					rem_nxt = trial;
					quo_nxt = {quo_r[W-2:0], 1'b0};
				end
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == ($clog2(W+1))'(1))
				begin
					q_out_nxt = neg_r ? (~quo_nxt + 1'b1) : quo_nxt;
					done_nxt = 1'b1;
					state_nxt = aeacc_pkg::DIV_IDLE;
				end
			end
			default:
			begin
				state_nxt = aeacc_pkg::DIV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			state_r <= aeacc_pkg::DIV_IDLE;
			dvd_r <= '0;
			quo_r <= '0;
			rem_r <= '0;
			dsr_r <= '0;
			neg_r <= 1'b0;
			cnt_r <= '0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
			quotient_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			dvd_r <= dvd_nxt;
			quo_r <= quo_nxt;
			rem_r <= rem_nxt;
			dsr_r <= dsr_nxt;
			neg_r <= neg_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			busy_r <= (state_nxt == aeacc_pkg::DIV_RUN);
			quotient_r <= q_out_nxt;
		end
	end

endmodule // aeacc_div

// >>> rtl/aeacc_pulse.sv
// Energy pulse generator: gained active power to a rational-divided pulse.
// Assumes power_in is the averaged active power word, valid every clock.
`timescale 1ns/10ps
module aeacc_pulse #(
	parameter int PW = 24
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic signed [PW-1:0] power_in,
	input wire logic signed [aeacc_pkg::GAIN_W-1:0] gain,
	input wire logic [aeacc_pkg::CFDIV_W-1:0] num,
	input wire logic [aeacc_pkg::CFDIV_W-1:0] den,
	output logic pulse_r
);

	localparam int PRW = PW + aeacc_pkg::GAIN_W;
	localparam int RW = aeacc_pkg::CFDIV_W + 2;

	generate
		if (PW + 2 > aeacc_pkg::PHASE_W)
		begin : g_chk
			$error("aeacc_pulse: power word too wide for the phase");
		end
	endgenerate

	logic signed [PRW-1:0] prod;
	logic signed [PW+1:0] gained;
	logic [aeacc_pkg::PHASE_W-1:0] mag;
	logic [aeacc_pkg::PHASE_W:0] phase_sum;
	logic [aeacc_pkg::PHASE_W-1:0] phase_r, phase_nxt;
	logic [RW-1:0] ratio_r, ratio_nxt, ratio_sum;
	logic pulse_nxt;

	always_comb
	begin
		// One LSB of gain is 1/4096 of full scale
		prod = PRW'(power_in) * PRW'(gain);
		gained = (PW+2)'(power_in) + (PW+2)'(prod >>> aeacc_pkg::GAIN_W);
		mag = gained[PW+1] ? aeacc_pkg::PHASE_W'(-gained)
			: aeacc_pkg::PHASE_W'(gained);
		// Carry out of a 2^29 phase gives power * fclk / 2^29
		phase_sum = {1'b0, phase_r} + {1'b0, mag};
		phase_nxt = phase_sum[aeacc_pkg::PHASE_W-1:0];
		ratio_nxt = ratio_r;
		pulse_nxt = 1'b0;
		ratio_sum = ratio_r + RW'(num) + RW'(1);
		if (phase_sum[aeacc_pkg::PHASE_W])
		begin
			// Scale by (num + 1) / (den + 1)
			if (ratio_sum >= RW'(den) + RW'(1))
			begin
				pulse_nxt = 1'b1;
				ratio_nxt = ratio_sum - RW'(den) - RW'(1);
				if (ratio_nxt > RW'(den))
				begin
					ratio_nxt = RW'(den);
				end
			end
			else
			begin
				ratio_nxt = ratio_sum;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			phase_r <= '0;
			ratio_r <= '0;
			pulse_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			ratio_r <= ratio_nxt;
			pulse_r <= pulse_nxt;
		end
	end

endmodule // aeacc_pulse

// >>> rtl/aeacc_top.sv
// Apparent energy accumulator with line-cycle accumulation and pulse out.
// Assumes power samples and the half-cycle strobe are synchronous to clk_sys.
//
// How it works
// - Wide accumulator divided by divisor before visible
// - Divisor is unsigned 8-bit, zero acts as one
// - Upper 24 divided bits form energy total
// - Read-clear copy of energy zeroes on each read
// - Positive overflow wraps to full-scale negative
// - Half-full and over/underflow raise maskable events
// - One sample added every four clocks
// - Accumulator is signed 52 bits
// - Line apparent energy over whole half cycles
// - Line apparent accumulation always runs
// - Half-cycle count is unsigned 16-bit
// - Line active and apparent share one period
// - End of period sets end-of-cycle flag
// - Unmasked end-of-cycle drives interrupt low
// - Line energy bypasses the divisor, total is divided
// - Mode bit 7 enables line active accumulation
// - Pulse scaled by (num+1)/(den+1), at most one per carry
// - Undivided pulse rate is power times fclk/2^29
// - Active gain scales pulse, 1/4096 per LSB
// - Samples are added as signed values
`timescale 1ns/10ps
module aeacc_top #(
	parameter int SAMPLE_W = 24
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire aeacc_pkg::aeacc_req_s req,
	input wire logic signed [SAMPLE_W-1:0] app_power_in,
	input wire logic signed [SAMPLE_W-1:0] act_power_in,
	input wire logic zero_cross_in,
	output logic [aeacc_pkg::DATA_W-1:0] rdata_r,
	output logic rvalid_r,
	output logic irq_n_r,
	output logic energy_pulse_out_r
);

	localparam int ACC_W = aeacc_pkg::ACC_W;
	localparam int TOT_W = aeacc_pkg::TOT_W;
	localparam int TOT_LSB = aeacc_pkg::TOT_LSB;
	localparam int TICK_W = $clog2(aeacc_pkg::TICK_CLKS);

	generate
		if (SAMPLE_W < 2 || SAMPLE_W + 2 > aeacc_pkg::PHASE_W)
		begin : g_chk
			$error("aeacc_top: unsupported sample width");
		end
	endgenerate

	// Register write strobe for one address
	function automatic logic wr_hit(aeacc_pkg::aeacc_req_s r,
		logic [aeacc_pkg::ADDR_W-1:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	// ************************************************************
	// Software settings
	// ************************************************************
	logic [aeacc_pkg::DIVISOR_W-1:0] div_r, div_nxt;
	logic [aeacc_pkg::HCYC_W-1:0] hcyc_r, hcyc_nxt;
	logic [aeacc_pkg::MODE_W-1:0] mode_r, mode_nxt;
	logic [aeacc_pkg::ST_W-1:0] mask_r, mask_nxt;
	logic [aeacc_pkg::GAIN_W-1:0] gain_r, gain_nxt;
	logic [aeacc_pkg::CFDIV_W-1:0] num_r, num_nxt;
	logic [aeacc_pkg::CFDIV_W-1:0] den_r, den_nxt;

	always_comb
	begin
		div_nxt = div_r;
		hcyc_nxt = hcyc_r;
		mode_nxt = mode_r;
		mask_nxt = mask_r;
		gain_nxt = gain_r;
		num_nxt = num_r;
		den_nxt = den_r;
		if (wr_hit(req, aeacc_pkg::A_DIVISOR))
		begin
			div_nxt = req.wdata[aeacc_pkg::DIVISOR_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_HALF_CYC))
		begin
			hcyc_nxt = req.wdata[aeacc_pkg::HCYC_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_MODE))
		begin
			mode_nxt = req.wdata[aeacc_pkg::MODE_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_IRQ_MASK))
		begin
			mask_nxt = req.wdata[aeacc_pkg::ST_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_ACT_GAIN))
		begin
			gain_nxt = req.wdata[aeacc_pkg::GAIN_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_CF_NUM))
		begin
			num_nxt = req.wdata[aeacc_pkg::CFDIV_W-1:0];
		end
		if (wr_hit(req, aeacc_pkg::A_CF_DEN))
		begin
			den_nxt = req.wdata[aeacc_pkg::CFDIV_W-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			div_r <= aeacc_pkg::DIVISOR_RST;
			hcyc_r <= aeacc_pkg::HALF_CYC_RST;
			mode_r <= aeacc_pkg::MODE_RST;
			mask_r <= '0;
			gain_r <= '0;
			num_r <= '0;
			den_r <= '0;
		end
		else
		begin
			div_r <= div_nxt;
			hcyc_r <= hcyc_nxt;
			mode_r <= mode_nxt;
			mask_r <= mask_nxt;
			gain_r <= gain_nxt;
			num_r <= num_nxt;
			den_r <= den_nxt;
		end
	end

	// ************************************************************
	// Sample tick and the wide accumulators
	// ************************************************************
	logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
	logic tick;
	logic signed [ACC_W-1:0] acc_r, acc_nxt;
	logic signed [ACC_W-1:0] lacc_r, lacc_nxt, lacc_sum;
	logic signed [ACC_W-1:0] wacc_r, wacc_nxt, wacc_sum;
	logic [aeacc_pkg::HCYC_W-1:0] hc_cnt_r, hc_cnt_nxt, hc_goal;
	logic [TOT_W-1:0] lapp_r, lapp_nxt, lact_r, lact_nxt;
	logic eoc;
	logic line_act_on;

	always_comb
	begin
		tick_cnt_nxt = tick_cnt_r + 1'b1;
		tick = (tick_cnt_r == TICK_W'(aeacc_pkg::TICK_CLKS - 1));
		line_act_on = mode_r[aeacc_pkg::MODE_LINE_CYC_BIT];
		// Signed add even though apparent power is never negative
		acc_nxt = tick ? acc_r + ACC_W'(app_power_in) : acc_r;
		lacc_sum = tick ? lacc_r + ACC_W'(app_power_in) : lacc_r;
		wacc_sum = (tick && line_act_on) ? wacc_r + ACC_W'(act_power_in)
			: wacc_r;
		// A zero count behaves as a single half cycle
		hc_goal = (hcyc_r == '0) ? aeacc_pkg::HCYC_W'(1) : hcyc_r;
		eoc = zero_cross_in && (hc_cnt_r + 1'b1 >= hc_goal);
		hc_cnt_nxt = zero_cross_in ? (eoc ? '0 : hc_cnt_r + 1'b1)
			: hc_cnt_r;
		lapp_nxt = lapp_r;
		lact_nxt = lact_r;
		lacc_nxt = lacc_sum;
		wacc_nxt = line_act_on ? wacc_sum : '0;
		if (eoc)
		begin
			// Both line results close on the same half cycle
			lapp_nxt = lacc_sum[ACC_W-1:TOT_LSB];
			lacc_nxt = '0;
			if (line_act_on)
			begin
				lact_nxt = wacc_sum[ACC_W-1:TOT_LSB];
				wacc_nxt = '0;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tick_cnt_r <= '0;
			acc_r <= '0;
			lacc_r <= '0;
			wacc_r <= '0;
			hc_cnt_r <= '0;
			lapp_r <= '0;
			lact_r <= '0;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_nxt;
			acc_r <= acc_nxt;
			lacc_r <= lacc_nxt;
			wacc_r <= wacc_nxt;
			hc_cnt_r <= hc_cnt_nxt;
			lapp_r <= lapp_nxt;
			lact_r <= lact_nxt;
		end
	end

	// ************************************************************
	// Divided energy and its events
	// ************************************************************
	logic [ACC_W-1:0] quo;
	logic div_done, div_busy;
	logic [TOT_W-1:0] tot_r, tot_nxt, new_tot;
	logic [TOT_W-1:0] rc_base_r, rc_base_nxt;
	logic [aeacc_pkg::ST_W-1:0] st_r, st_nxt, st_set;
	logic rd_status, rd_rclr;

	// A new division starts as soon as the last ends, so the total
	// trails the accumulator by about one division time.
	aeacc_div #(
		.W(ACC_W),
		.DW(aeacc_pkg::DIVISOR_W)
	) u_div (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(!div_busy),
		.dividend(acc_r),
		.divisor(div_r),
		.quotient_r(quo),
		.done_r(div_done),
		.busy_r(div_busy)
	);

	always_comb
	begin
		new_tot = quo[ACC_W-1:TOT_LSB];
		tot_nxt = div_done ? new_tot : tot_r;
		rd_status = req.rd && (req.addr == aeacc_pkg::A_IRQ_STATUS);
		rd_rclr = req.rd && (req.addr == aeacc_pkg::A_ENERGY_RCLR);
		// Moving the base to the total makes the copy read zero after
		rc_base_nxt = rd_rclr ? tot_r : rc_base_r;
		st_set = '0;
		if (div_done)
		begin
			// Two's complement wrap lands on full-scale negative
			st_set[aeacc_pkg::ST_OVF] = !tot_r[TOT_W-1] && tot_r[TOT_W-2]
				&& new_tot[TOT_W-1];
			st_set[aeacc_pkg::ST_UNF] = tot_r[TOT_W-1] && !tot_r[TOT_W-2]
				&& !new_tot[TOT_W-1];
			st_set[aeacc_pkg::ST_HALF_POS] = !new_tot[TOT_W-1]
				&& new_tot[TOT_W-2] && !tot_r[TOT_W-2];
			st_set[aeacc_pkg::ST_HALF_NEG] = new_tot[TOT_W-1]
				&& !new_tot[TOT_W-2] && tot_r[TOT_W-2];
		end
		st_set[aeacc_pkg::ST_EOC] = eoc;
		// A new event beats a clearing read in the same cycle
		st_nxt = (rd_status ? '0 : st_r) | st_set;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tot_r <= '0;
			rc_base_r <= '0;
			st_r <= '0;
			irq_n_r <= 1'b1;
		end
		else
		begin
			tot_r <= tot_nxt;
			rc_base_r <= rc_base_nxt;
			st_r <= st_nxt;
			irq_n_r <= ~|(st_nxt & mask_r);
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	logic [aeacc_pkg::DATA_W-1:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = '0;
		case (req.addr)
			aeacc_pkg::A_ENERGY_TOTAL: rdata_nxt = tot_r;
			aeacc_pkg::A_ENERGY_RCLR: rdata_nxt = tot_r - rc_base_r;
			aeacc_pkg::A_LINE_APP: rdata_nxt = lapp_r;
			aeacc_pkg::A_LINE_ACT: rdata_nxt = lact_r;
			aeacc_pkg::A_DIVISOR: rdata_nxt = 24'(div_r);
			aeacc_pkg::A_HALF_CYC: rdata_nxt = 24'(hcyc_r);
			aeacc_pkg::A_MODE: rdata_nxt = 24'(mode_r);
			aeacc_pkg::A_IRQ_MASK: rdata_nxt = 24'(mask_r);
			aeacc_pkg::A_IRQ_STATUS: rdata_nxt = 24'(st_r);
			aeacc_pkg::A_ACT_GAIN: rdata_nxt = 24'(gain_r);
			aeacc_pkg::A_CF_NUM: rdata_nxt = 24'(num_r);
			aeacc_pkg::A_CF_DEN: rdata_nxt = 24'(den_r);
			default: rdata_nxt = '0;
		endcase
		if (!req.rd)
		begin
			rdata_nxt = rdata_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			rvalid_r <= req.rd;
		end
	end

	// ************************************************************
	// Energy pulse output
	// ************************************************************
	aeacc_pulse #(
		.PW(SAMPLE_W)
	) u_pulse (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.power_in(act_power_in),
		.gain(gain_r),
		.num(num_r),
		.den(den_r),
		.pulse_r(energy_pulse_out_r)
	);

endmodule // aeacc_top

// >>> tb/aeacc_mcu_model.sv
// Pulse counter standing in for the metering controller.
// Assumes energy pulses are one clk_sys cycle wide.
`timescale 1ns/10ps
module aeacc_mcu_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic pulse,
	input wire logic clr,
	output int count
);
	// ************************************************************
	// Pulse count
	// ************************************************************
	// Counts high cycles, so a stretched pulse shows as a surplus
	always @(posedge clk_sys)
	begin
		if (!rstn || clr)
			count <= 0;
		else if (pulse)
			count <= count + 1;
	end
endmodule // aeacc_mcu_model

// >>> tb/aeacc_monitor.sv
// Port checker for aeacc_top, bound to every instance.
// Assumes one clk_sys domain and one-cycle request strobes.
`timescale 1ns/10ps
module aeacc_monitor #(
	parameter int SAMPLE_W = 24
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire aeacc_pkg::aeacc_req_s req,
	input wire logic signed [SAMPLE_W-1:0] app_power_in,
	input wire logic signed [SAMPLE_W-1:0] act_power_in,
	input wire logic zero_cross_in,
	input wire logic [aeacc_pkg::DATA_W-1:0] rdata_r,
	input wire logic rvalid_r,
	input wire logic irq_n_r,
	input wire logic energy_pulse_out_r
);
	// ************************************************************
	// Register shadows
	// ************************************************************
	logic [4:0] mask_r;
	logic [15:0] hc_r;
	logic [7:0] div_r;
	logic [15:0] zx_cnt_r;
	logic [15:0] hc_tgt;
	logic eoc;
	assign hc_tgt = (hc_r == 16'h0000) ? 16'h0001 : hc_r;
	assign eoc = zero_cross_in && (zx_cnt_r == hc_tgt - 16'h0001);
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			mask_r <= 5'h00;
			hc_r <= 16'h0000;
			div_r <= 8'h00;
			zx_cnt_r <= 16'h0000;
		end
		else
		begin
			if (req.wr && req.addr == aeacc_pkg::A_IRQ_MASK)
				mask_r <= req.wdata[4:0];
			if (req.wr && req.addr == aeacc_pkg::A_HALF_CYC)
				hc_r <= req.wdata[15:0];
			if (req.wr && req.addr == aeacc_pkg::A_DIVISOR)
				div_r <= req.wdata[7:0];
			if (eoc)
				zx_cnt_r <= 16'h0000;
			else if (zero_cross_in)
				zx_cnt_r <= zx_cnt_r + 16'h0001;
		end
	end
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	AST_RESET_IDLE: assert property ($rose(rstn) |->
		irq_n_r && !rvalid_r && !energy_pulse_out_r)
		else $error("outputs not idle after reset");
	AST_RVALID: assert property (req.rd |=> rvalid_r)
		else $error("read not answered next cycle");
	AST_RDATA_HOLD: assert property (!rvalid_r |-> $stable(rdata_r))
		else $error("read data moved without a read");
	AST_UNMAPPED: assert property (req.rd && (req.addr == 5'h00 ||
		req.addr > aeacc_pkg::A_CF_DEN) |=> rdata_r == 24'h000000)
		else $error("unmapped read not zero");
	AST_DIV_READBACK: assert property (req.rd && !req.wr &&
		req.addr == aeacc_pkg::A_DIVISOR |=> rdata_r == {16'h0000, div_r})
		else $error("divisor readback wrong");
	AST_HC_READBACK: assert property (req.rd && !req.wr &&
		req.addr == aeacc_pkg::A_HALF_CYC |=> rdata_r == {8'h00, hc_r})
		else $error("half cycle count readback wrong");
	AST_EOC_IRQ: assert property (eoc && mask_r[4] && !req.wr
		|-> ##[1:3] !irq_n_r)
		else $error("end of line cycle gave no interrupt");
	AST_MASKED: assert property (mask_r == 5'h00 [*2] |-> irq_n_r)
		else $error("interrupt low while all masked");
	AST_PULSE_GAP: assert property (energy_pulse_out_r |=>
		!energy_pulse_out_r [*8])
		else $error("energy pulses too close");
	AST_ZERO_POWER: assert property ((act_power_in == 0) [*6] |->
		!energy_pulse_out_r)
		else $error("pulse without active power");
	cover property (eoc && mask_r[4]);
	cover property (energy_pulse_out_r);
	cover property (req.rd && req.addr == aeacc_pkg::A_ENERGY_RCLR);
endmodule // aeacc_monitor

bind aeacc_top aeacc_monitor #(.SAMPLE_W(SAMPLE_W)) i_mon (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.req(req),
	.app_power_in(app_power_in),
	.act_power_in(act_power_in),
	.zero_cross_in(zero_cross_in),
	.rdata_r(rdata_r),
	.rvalid_r(rvalid_r),
	.irq_n_r(irq_n_r),
	.energy_pulse_out_r(energy_pulse_out_r)
);

// >>> tb/tb_apparent_energy_accumulator.sv
// Self-checking bench of aeacc_top against an integer model.
// Assumes the pulse counter model and the bound port checker.
`timescale 1ns/10ps
module tb_apparent_energy_accumulator;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	aeacc_pkg::aeacc_req_s req = '0;
	logic signed [23:0] app_power_in = 24'h000000;
	logic signed [23:0] act_power_in = 24'h000000;
	logic zero_cross_in = 1'b0;
	logic [23:0] rdata_r;
	logic rvalid_r;
	logic irq_n_r;
	logic energy_pulse_out_r;
	logic cnt_clr = 1'b0;
	int pulse_cnt;
	int error_cnt = 0;
	int total_checks = 0;
	logic signed [51:0] m_acc = '0;
	logic signed [51:0] m_lapp = '0;
	logic signed [51:0] m_lact = '0;
	logic [23:0] m_lapp_reg = '0;
	logic [23:0] m_lact_reg = '0;
	logic [15:0] m_hc = '0;
	logic [7:0] m_mode = '0;
	logic [7:0] m_div = '0;
	int m_tick = 0;
	int m_zx = 0;
	int cf_p[5] = '{4194304, -4194304, 4194304, 4194304, 4194304};
	int cf_g[5] = '{0, 0, 1024, 0, 0};
	int cf_n[5] = '{0, 0, 0, 2, 3};
	int cf_d[5] = '{0, 0, 0, 4, 1};
	int cf_w[5] = '{1280, 1280, 5120, 3200, 1280};
	int dv[4] = '{255, 3, 1, 0};

	always #10 clk_sys = ~clk_sys;

	aeacc_top i_dut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.req(req),
		.app_power_in(app_power_in),
		.act_power_in(act_power_in),
		.zero_cross_in(zero_cross_in),
		.rdata_r(rdata_r),
		.rvalid_r(rvalid_r),
		.irq_n_r(irq_n_r),
		.energy_pulse_out_r(energy_pulse_out_r)
	);
	aeacc_mcu_model i_mcu (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pulse(energy_pulse_out_r),
		.clr(cnt_clr),
		.count(pulse_cnt)
	);

	// ************************************************************
	// Reference model
	// ************************************************************
	always @(posedge clk_sys)
	begin : model
		logic signed [51:0] sa;
		logic signed [51:0] sc;
		logic signed [51:0] t;
		sa = (m_tick == 3) ? 52'(app_power_in) : '0;
		sc = (m_tick == 3) ? 52'(act_power_in) : '0;
		m_tick = rstn ? (m_tick + 1) % 4 : 0;
		m_acc = m_acc + sa;
		if (zero_cross_in && m_zx + 1 >= ((m_hc == 0) ? 1 : m_hc))
		begin
			t = m_lapp + sa;
			m_lapp_reg = t[51:28];
			m_lapp = '0;
			t = m_lact + sc;
			if (m_mode[7])
				m_lact_reg = t[51:28];
			m_lact = '0;
			m_zx = 0;
		end
		else
		begin
			m_lapp = m_lapp + sa;
			m_lact = m_mode[7] ? m_lact + sc : '0;
			m_zx = m_zx + (zero_cross_in ? 1 : 0);
		end
		if (req.wr && req.addr == aeacc_pkg::A_HALF_CYC)
			m_hc = req.wdata[15:0];
		if (req.wr && req.addr == aeacc_pkg::A_MODE)
			m_mode = req.wdata[7:0];
		if (req.wr && req.addr == aeacc_pkg::A_DIVISOR)
			m_div = req.wdata[7:0];
	end

	function automatic logic [23:0] exp_total();
		longint q;
		q = longint'(m_acc) / longint'((m_div == 0) ? 8'h01 : m_div);
		return q[51:28];
	endfunction

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
		@(posedge clk_sys) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys) req <= '0;
	endtask

	task automatic rd_reg(input logic [4:0] a, output logic [23:0] v);
		@(posedge clk_sys) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 0};
		@(posedge clk_sys) req <= '0;
		#1 v = rdata_r;
	endtask

	// Total moves only when the divider pass ends, so poll for it
	task automatic poll_total(input logic [23:0] exp);
		int i;
		logic [23:0] v;
		for (i = 0; i < 30; i++)
		begin
			rd_reg(aeacc_pkg::A_ENERGY_TOTAL, v);
			if (v === exp)
				break;
			repeat (20) @(posedge clk_sys);
		end
		check(v, exp);
		if (i == 30)
			print_verdict();
	endtask

	task automatic run_period(input logic [15:0] hc, input logic [7:0] md,
		input logic [4:0] mk);
		logic [23:0] v;
		wr_reg(aeacc_pkg::A_HALF_CYC, {8'h00, hc});
		wr_reg(aeacc_pkg::A_MODE, {16'h0000, md});
		wr_reg(aeacc_pkg::A_IRQ_MASK, {19'h00000, mk});
		rd_reg(aeacc_pkg::A_HALF_CYC, v);
		check(v, {8'h00, hc});
		repeat ((hc == 0) ? 1 : hc)
		begin
			repeat (300) @(posedge clk_sys)
			begin
				app_power_in <= 24'($urandom_range(8388607, 4194304));
				act_power_in <= 24'($urandom_range(8388607, 4194304));
			end
			zero_cross_in <= 1'b1;
			@(posedge clk_sys) zero_cross_in <= 1'b0;
		end
		repeat (6) @(posedge clk_sys);
		#1 check({23'h000000, irq_n_r}, {23'h000000, ~mk[4]});
		rd_reg(aeacc_pkg::A_IRQ_STATUS, v);
		check(v, 24'h000010);
		rd_reg(aeacc_pkg::A_LINE_APP, v);
		check(v, m_lapp_reg);
		rd_reg(aeacc_pkg::A_LINE_ACT, v);
		check(v, m_lact_reg);
		repeat (3) @(posedge clk_sys);
		#1 check(24'(irq_n_r), 24'h000001);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end

	initial
	begin : main
		logic [23:0] v;
		logic [23:0] e;
		longint c;
		longint p;
		v = 24'($urandom(52));
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_reg(aeacc_pkg::A_DIVISOR, v);
		check(v, 24'h000000);
		rd_reg(aeacc_pkg::A_HALF_CYC, v);
		check(v, 24'h000000);
		wr_reg(5'h1F, 24'hFFFFFF);
		rd_reg(5'h1F, v);
		check(v, 24'h000000);
		wr_reg(aeacc_pkg::A_ENERGY_TOTAL, 24'hFFFFFF);
		run_period(16'h0003, 8'h00, 5'h10);
		run_period(16'h0000, 8'h80, 5'h10);
		run_period(16'h0002, 8'h80, 5'h00);
		repeat (2000) @(posedge clk_sys)
			app_power_in <= 24'($urandom_range(8388607, 0)) - 24'h200000;
		@(posedge clk_sys) app_power_in <= 24'h000000;
		act_power_in <= 24'h000000;
		repeat (8) @(posedge clk_sys);
		foreach (dv[i])
		begin
			wr_reg(aeacc_pkg::A_DIVISOR, 24'(dv[i]));
			rd_reg(aeacc_pkg::A_DIVISOR, v);
			check(v, 24'(dv[i]));
			poll_total(exp_total());
		end
		e = exp_total();
		rd_reg(aeacc_pkg::A_ENERGY_RCLR, v);
		check(v, e);
		rd_reg(aeacc_pkg::A_ENERGY_RCLR, v);
		check(v, 24'h000000);
		rd_reg(aeacc_pkg::A_ENERGY_TOTAL, v);
		check(v, e);
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk_sys) act_power_in <= 24'(cf_p[k]);
			wr_reg(aeacc_pkg::A_ACT_GAIN, 24'(cf_g[k]));
			wr_reg(aeacc_pkg::A_CF_NUM, 24'(cf_n[k]));
			wr_reg(aeacc_pkg::A_CF_DEN, 24'(cf_d[k]));
			repeat (800) @(posedge clk_sys);
			cnt_clr <= 1'b1;
			@(posedge clk_sys) cnt_clr <= 1'b0;
			repeat (cf_w[k]) @(posedge clk_sys);
			p = (cf_p[k] < 0) ? -cf_p[k] : cf_p[k];
			c = longint'(cf_w[k]) * p * (4096 + cf_g[k]) / 4096 / (2 ** 29);
			c = (cf_n[k] > cf_d[k]) ? c : c * (cf_n[k] + 1) / (cf_d[k] + 1);
			#1 check(24'(pulse_cnt), 24'(c));
		end
		print_verdict();
	end
endmodule // tb_apparent_energy_accumulator
